/* pkg/cmsd_defines.vh */
// Address map, field positions and reset values of the core memory space decoder.
// Included by the top design file of the decoder only; definitions only.
`ifndef CMSD_DEFINES_VH
`define CMSD_DEFINES_VH
`define CMSD_PROG_TOP 16'h1dff
`define CMSD_DATA_TOP 8'hff
`define CMSD_UPPER_BASE 8'h80
`define CMSD_BIT_BASE 8'h20
`define CMSD_SP_ADDR 8'h81
`define CMSD_PSW_ADDR 8'hd0
`define CMSD_PROGRAM_STORE_CONTROL_ADDR 8'h8f
`define CMSD_SP_RESET 8'h07
`define CMSD_PSW_RESET 8'h00
`define CMSD_PROGRAM_STORE_CONTROL_RESET 8'h00
`define CMSD_PSW_RS0 3
`define CMSD_PSW_RS1 4
`define CMSD_PROGRAM_STORE_CONTROL_WEN 0
`define CMSD_SFR_BITCAP_LO 3'h0
`define CMSD_MODE_DIRECT 2'h0
`define CMSD_MODE_INDIRECT 2'h1
`define CMSD_MODE_REG 2'h2
`endif

/* rtl/cmsd_ram.v */
// Byte-wide flip-flop store with one write port and two read ports.
// Assumes the caller resolves the address; reads are combinational.
`timescale 1ns/1ns
module cmsd_ram #(
   parameter AW = 7,
   parameter DEPTH = 128
) (
   input wire core_clk_in, // Core clock
   input wire we_in, // Write strobe
   input wire [AW-1:0] waddr_in, // Write address
   input wire [7:0] wdata_in, // Write data
   input wire [AW-1:0] raddr_a_in, // Read address a
   output wire [7:0] rdata_a_out, // Read data a
   input wire [AW-1:0] raddr_b_in, // Read address b
   output wire [7:0] rdata_b_out // Read data b
);
   reg [7:0] mem_reg [0:DEPTH-1];
   // No reset: data RAM contents are undefined after reset
   always @(posedge core_clk_in) begin
      if (we_in) begin
         mem_reg[waddr_in] <= wdata_in;
      end
   end
   assign rdata_a_out = mem_reg[raddr_a_in];
   assign rdata_b_out = mem_reg[raddr_b_in];
endmodule // cmsd_ram

/* rtl/cmsd_prog_store.v */
// Program store: byte-wide store over the implemented program range.
// Assumes the caller qualifies writes with the store-enable control.
`timescale 1ns/1ns
module cmsd_prog_store #(
   parameter AW = 13,
   parameter DEPTH = 7680
) (
   input wire core_clk_in, // Core clock
   input wire we_in, // Write strobe
   input wire [AW-1:0] addr_in, // Byte address
   input wire [7:0] wdata_in, // Write data
   output reg [7:0] rdata_out // Registered read data
);
   reg [7:0] mem_reg [0:DEPTH-1];
   always @(posedge core_clk_in) begin
      if (we_in) begin
         mem_reg[addr_in] <= wdata_in;
      end
      rdata_out <= mem_reg[addr_in];
   end
endmodule // cmsd_prog_store

/* rtl/cmsd_core_memory.v */
// Memory space decoder for a small microcontroller core: program store, 256-byte data RAM,
// register banks, bit region, special function space with stack pointer and status word.
// Assumes one access request per cycle from the execution unit, synchronous to core_clk_in.
// Notes on behaviour
// - Program store spans 0x0000 to 0x1dff; higher addresses are reserved.
// - Program store is read-only unless store-write enable is set on xdata write.
// - Data RAM holds 256 bytes at addresses 0x00 to 0xff.
// - Lower 128 bytes reachable by direct and indirect addressing.
// - Bytes 0x00 to 0x1f form four banks of eight registers, one active.
// - Two bank-select bits pick bank n at n times eight.
// - Upper 128 data bytes only reachable indirectly, or directly by byte access with acc_mode_in 3.
// - Direct above 0x7f goes to special registers; indirect to upper RAM.
// - Registers zero and one of the active bank serve as index registers.
// - Bytes 0x20 to 0x2f give 128 bits; bit address is offset*8 plus position.
// - Bit or byte access chosen only by the instruction operand type.
// - Push writes at pointer plus one, then pointer increments.
// - Stack pointer resets to seven.
// - Stack may lie anywhere in 256-byte data RAM.
// - Special registers at direct 0x80 to 0xff; stack pointer at 0x81.
// - Special registers with low nibble 0 or 8 are also bit-addressable.
// - 64 kB program space; only the implemented range holds storage.
`timescale 1ns/1ns
`include "cmsd_defines.vh"
module cmsd_core_memory #(
   parameter PROG_DEPTH = 7680
) (
   input wire core_clk_in, // Core clock, 20 MHz
   input wire rst_in, // Asynchronous reset, active high
   input wire [15:0] prog_addr_in, // Program address, 64 kB space
   input wire prog_rd_in, // Program fetch strobe
   input wire xdata_move_instr_wr_in, // Xdata move write to program store
   input wire [7:0] prog_wdata_in, // Program write data
   output reg [7:0] prog_rdata_out, // Program read data
   output reg prog_valid_out, // Read data valid, one cycle
   output reg prog_reserved_out, // Last access hit reserved range
   input wire acc_req_in, // Data access strobe
   input wire acc_wr_in, // 1 write, 0 read
   input wire [1:0] acc_mode_in, // Direct, indirect or bank register
   input wire acc_bit_in, // Bit operand, else byte
   input wire [7:0] acc_addr_in, // Byte address, bit address or register number
   input wire [7:0] acc_wdata_in, // Write byte; bit value in bit 0
   input wire push_in, // Push strobe
   input wire pop_in, // Pop strobe
   output reg [7:0] rdata_out, // Read data, byte or bit in bit 0
   output reg rdata_valid_out, // Read data valid, one cycle
   output reg sfr_sel_out, // Access went to peripheral register space
   output reg sfr_wr_out, // Write pulse to outside peripheral register
   output reg [7:0] sfr_addr_out, // Peripheral register address
   output reg [7:0] sfr_wdata_out, // Peripheral register write data
   input wire [7:0] sfr_rdata_in, // Outside peripheral register read data
   output wire [7:0] stack_pointer_out, // Stack pointer
   output wire [7:0] processor_status_word_out, // Status word
   output wire [7:0] index_reg_zero_out, // Active bank register zero
   output wire [7:0] index_reg_one_out // Active bank register one
);
   reg [7:0] stack_pointer_reg;
   reg [7:0] stack_pointer_next;
   reg [7:0] processor_status_word_reg;
   reg [7:0] psw_next;
   reg [7:0] program_store_control_reg;
   reg [7:0] pstore_next;
   reg ram_we;
   reg [7:0] ram_waddr;
   reg [7:0] ram_wdata;
   reg [7:0] ram_raddr;
   reg [7:0] eff_addr;
   reg is_sfr;
   reg [7:0] sfr_byte;
   reg [2:0] bit_pos;
   reg bit_ok;
   reg [7:0] rd_byte;
   reg [7:0] rd_next;
   reg [7:0] local_sfr;
   reg local_hit;
   wire [1:0] bank_sel;
   wire [7:0] ram_rdata;
   wire [7:0] ram_rdata_idx;
   wire [7:0] ram_rdata_lo;
   wire [7:0] ram_rdata_hi;
   wire [7:0] ram_idx_lo;
   wire [7:0] ram_idx_hi;
   wire [7:0] bank_base;
   wire prog_in_range;
   wire prog_we;
   wire [7:0] prog_store_rdata;

   assign bank_sel = {processor_status_word_reg[`CMSD_PSW_RS1], processor_status_word_reg[`CMSD_PSW_RS0]};
   assign bank_base = {3'h0, bank_sel, 3'h0};
   assign stack_pointer_out = stack_pointer_reg;
   assign processor_status_word_out = processor_status_word_reg;

   // Program store, 64 kB space with only the implemented range backed
   assign prog_in_range = (prog_addr_in <= `CMSD_PROG_TOP);
   assign prog_we = xdata_move_instr_wr_in & prog_in_range
      & program_store_control_reg[`CMSD_PROGRAM_STORE_CONTROL_WEN];
   cmsd_prog_store #(
      .AW(13),
      .DEPTH(PROG_DEPTH)
   ) u_prog (
      .core_clk_in(core_clk_in),
      .we_in(prog_we),
      .addr_in(prog_addr_in[12:0]),
      .wdata_in(prog_wdata_in),
      .rdata_out(prog_store_rdata)
   );
   reg prog_hit_reg;
   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prog_valid_out <= 1'b0;
         prog_reserved_out <= 1'b0;
         prog_hit_reg <= 1'b0;
      end else begin
         prog_valid_out <= prog_rd_in;
         prog_hit_reg <= prog_in_range;
         if (prog_rd_in | xdata_move_instr_wr_in) begin
            prog_reserved_out <= ~prog_in_range;
         end
      end
   end
   // Reserved addresses read as zero rather than aliasing into the store
   always @* begin
      prog_rdata_out = prog_hit_reg ? prog_store_rdata : 8'h00;
   end

   // Data RAM split into halves so both index registers and an operand can be read at once
   assign ram_rdata = ram_raddr[7] ? ram_rdata_hi : ram_rdata_lo;
   assign index_reg_zero_out = ram_idx_lo;
   assign index_reg_one_out = ram_idx_hi;
   cmsd_ram #(
      .AW(7),
      .DEPTH(128)
   ) u_ram_lo (
      .core_clk_in(core_clk_in),
      .we_in(ram_we & ~ram_waddr[7]),
      .waddr_in(ram_waddr[6:0]),
      .wdata_in(ram_wdata),
      .raddr_a_in(ram_raddr[6:0]),
      .rdata_a_out(ram_rdata_lo),
      .raddr_b_in(bank_base[6:0]),
      .rdata_b_out(ram_idx_lo)
   );
   cmsd_ram #(
      .AW(7),
      .DEPTH(128)
   ) u_ram_hi (
      .core_clk_in(core_clk_in),
      .we_in(ram_we & ram_waddr[7]),
      .waddr_in(ram_waddr[6:0]),
      .wdata_in(ram_wdata),
      .raddr_a_in(ram_raddr[6:0]),
      .rdata_a_out(ram_rdata_hi),
      .raddr_b_in(7'h00),
      .rdata_b_out()
   );
   // Second index register read through a bank-relative offset of one on a third port
   cmsd_ram #(
      .AW(5),
      .DEPTH(32)
   ) u_ram_bank_shadow (
      .core_clk_in(core_clk_in),
      .we_in(ram_we & (ram_waddr[7:5] == 3'h0)),
      .waddr_in(ram_waddr[4:0]),
      .wdata_in(ram_wdata),
      .raddr_a_in(bank_base[4:0] | 5'h01),
      .rdata_a_out(ram_idx_hi),
      .raddr_b_in(5'h00),
      .rdata_b_out()
   );
   assign ram_rdata_idx = acc_addr_in[0] ? ram_idx_hi : ram_idx_lo;

   // Local peripheral registers read mux
   always @* begin
      local_hit = 1'b1;
      case (sfr_byte)
         `CMSD_SP_ADDR: local_sfr = stack_pointer_reg;
         `CMSD_PSW_ADDR: local_sfr = processor_status_word_reg;
         `CMSD_PROGRAM_STORE_CONTROL_ADDR: local_sfr = program_store_control_reg;
         default: begin
            local_sfr = 8'h00;
            local_hit = 1'b0;
         end
      endcase
   end

   // Address decode and access steering
   always @* begin
      eff_addr = acc_addr_in;
      is_sfr = 1'b0;
      sfr_byte = acc_addr_in;
      bit_pos = 3'h0;
      bit_ok = 1'b1;
      ram_we = 1'b0;
      ram_waddr = 8'h00;
      ram_wdata = acc_wdata_in;
      ram_raddr = 8'h00;
      stack_pointer_next = stack_pointer_reg;
      psw_next = processor_status_word_reg;
      pstore_next = program_store_control_reg;
      rd_byte = 8'h00;
      rd_next = 8'h00;
      if (push_in) begin
         ram_we = 1'b1;
         ram_waddr = stack_pointer_reg + 8'h01;
         stack_pointer_next = stack_pointer_reg + 8'h01;
      end else if (pop_in) begin
         ram_raddr = stack_pointer_reg;
         rd_next = ram_rdata;
         stack_pointer_next = stack_pointer_reg - 8'h01;
      end else if (acc_req_in) begin
         case (acc_mode_in)
            `CMSD_MODE_REG: eff_addr = bank_base | {5'h00, acc_addr_in[2:0]};
            `CMSD_MODE_INDIRECT: eff_addr = ram_rdata_idx;
            default: eff_addr = acc_addr_in;
         endcase
         if (acc_bit_in) begin
            bit_pos = acc_addr_in[2:0];
            if (acc_addr_in[7]) begin
               is_sfr = 1'b1;
               sfr_byte = {acc_addr_in[7:3], `CMSD_SFR_BITCAP_LO};
            end else begin
               eff_addr = `CMSD_BIT_BASE + {4'h0, acc_addr_in[6:3]};
            end
         end else begin
            is_sfr = (acc_mode_in == `CMSD_MODE_DIRECT) & acc_addr_in[7];
            sfr_byte = acc_addr_in;
         end
         bit_ok = 1'b1;
         ram_raddr = eff_addr;
         // Outside read data belongs to the registered sfr_addr_out, so the caller holds the address a cycle ahead
         rd_byte = is_sfr ? (local_hit ? local_sfr : sfr_rdata_in) : ram_rdata;
         if (acc_bit_in) begin
            rd_next = {7'h00, rd_byte[bit_pos]};
         end else begin
            rd_next = rd_byte;
         end
         if (acc_wr_in) begin
            if (acc_bit_in) begin
               ram_wdata = rd_byte;
               ram_wdata[bit_pos] = acc_wdata_in[0]; // Read-modify-write of the holding byte
            end
            if (is_sfr) begin
               case (sfr_byte)
                  `CMSD_SP_ADDR: stack_pointer_next = ram_wdata;
                  `CMSD_PSW_ADDR: psw_next = ram_wdata;
                  `CMSD_PROGRAM_STORE_CONTROL_ADDR: pstore_next = ram_wdata;
                  default: psw_next = processor_status_word_reg;
               endcase
            end else begin
               ram_we = bit_ok;
               ram_waddr = eff_addr;
            end
         end
      end
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stack_pointer_reg <= `CMSD_SP_RESET;
         processor_status_word_reg <= `CMSD_PSW_RESET;
         program_store_control_reg <= `CMSD_PROGRAM_STORE_CONTROL_RESET;
         rdata_out <= 8'h00;
         rdata_valid_out <= 1'b0;
         sfr_sel_out <= 1'b0;
         sfr_wr_out <= 1'b0;
         sfr_addr_out <= 8'h00;
         sfr_wdata_out <= 8'h00;
      end else begin
         stack_pointer_reg <= stack_pointer_next;
         processor_status_word_reg <= psw_next;
         program_store_control_reg <= pstore_next;
         rdata_out <= rd_next;
         rdata_valid_out <= (pop_in | (acc_req_in & ~acc_wr_in)) & ~push_in;
         sfr_sel_out <= acc_req_in & ~push_in & ~pop_in & is_sfr;
         // Outside peripherals only see writes the decoder does not hold itself
         sfr_wr_out <= acc_req_in & ~push_in & ~pop_in & is_sfr & acc_wr_in & ~local_hit;
         sfr_addr_out <= sfr_byte;
         sfr_wdata_out <= ram_wdata;
      end
   end
endmodule // cmsd_core_memory

/* verification/cmsd_core_memory_properties.sv */
// Port properties of the memory space decoder.
// Assumes it is bound to cmsd_core_memory and sees one clock domain.
`timescale 1ns/1ns
module cmsd_core_memory_chk (
   input wire core_clk_in, // Clock
   input wire rst_in, // Reset
   input wire [15:0] prog_addr_in, // In
   input wire prog_rd_in, // In
   input wire [7:0] prog_rdata_out, // Out
   input wire prog_valid_out, // Out
   input wire prog_reserved_out, // Out
   input wire acc_req_in, // In
   input wire acc_wr_in, // In
   input wire [1:0] acc_mode_in, // In
   input wire acc_bit_in, // In
   input wire [7:0] acc_addr_in, // In
   input wire [7:0] acc_wdata_in, // In
   input wire push_in, // In
   input wire pop_in, // In
   input wire rdata_valid_out, // Out
   input wire sfr_sel_out, // Out
   input wire sfr_wr_out, // Out
   input wire [7:0] sfr_addr_out, // Out
   input wire [7:0] sfr_wdata_out, // Out
   input wire [7:0] stack_pointer_out // Out
);
   wire acc_q = acc_req_in & ~push_in & ~pop_in;
   wire rd_q = acc_q & ~acc_wr_in;
   wire pop_q = pop_in & ~push_in;
   // Writes to locally held registers never leave the block, so only the rest must go out
   wire loc = acc_addr_in == 8'h81 || acc_addr_in == 8'h8f || acc_addr_in == 8'hd0;
   wire ext_q = acc_q & ~acc_bit_in & acc_mode_in == 2'h0 & acc_addr_in[7] & ~loc;
   wire ram_q = acc_q & ~acc_bit_in & (acc_mode_in != 2'h0 | ~acc_addr_in[7]);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   a_sp_reset_seven: assert property ($fell(rst_in) |-> stack_pointer_out == 8'h07)
      else $error("stack pointer not seven after reset");
   a_push_sp_inc: assert property (push_in |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01)
      else $error("push did not raise stack pointer");
   a_pop_sp_dec: assert property (pop_q |=> rdata_valid_out && stack_pointer_out == $past(stack_pointer_out) - 8'h01)
      else $error("pop did not answer and lower stack pointer");
   a_read_answer: assert property (rd_q |=> rdata_valid_out)
      else $error("read got no answer");
   a_valid_cause: assert property (rdata_valid_out |-> $past(rd_q || pop_q))
      else $error("answer without a request");
   a_prog_answer: assert property (prog_rd_in |=> prog_valid_out)
      else $error("program read got no answer");
   a_prog_reserved: assert property (prog_rd_in && prog_addr_in > 16'h1dff |=> prog_reserved_out && prog_rdata_out == 8'h00)
      else $error("reserved program read mishandled");
   a_direct_goes_out: assert property (ext_q |=> sfr_sel_out && sfr_addr_out == $past(acc_addr_in))
      else $error("direct upper access not routed out");
   a_sfr_write_data: assert property (ext_q && acc_wr_in |=> sfr_wr_out && sfr_wdata_out == $past(acc_wdata_in))
      else $error("special register write lost");
   a_ram_stays_in: assert property (ram_q |=> !sfr_sel_out && !sfr_wr_out)
      else $error("data RAM access leaked out");
   c_push: cover property (push_in ##1 push_in);
   c_pop: cover property (pop_q ##1 pop_q);
   c_ext_wr: cover property (ext_q && acc_wr_in);
   c_resv: cover property (prog_rd_in && prog_addr_in > 16'h1dff);
endmodule // cmsd_core_memory_chk
bind cmsd_core_memory cmsd_core_memory_chk u_chk (.core_clk_in, .rst_in, .prog_addr_in, .prog_rd_in,
   .prog_rdata_out, .prog_valid_out, .prog_reserved_out, .acc_req_in, .acc_wr_in, .acc_mode_in, .acc_bit_in,
   .acc_addr_in, .acc_wdata_in, .push_in, .pop_in, .rdata_valid_out, .sfr_sel_out, .sfr_wr_out, .sfr_addr_out,
   .sfr_wdata_out, .stack_pointer_out);

/* verification/cmsd_periph_model.sv */
// Peripheral register file behind the forwarded special register accesses.
// Assumes one-cycle write pulses with address and data.
`timescale 1ns/1ns
module cmsd_periph_model (
   input wire core_clk_in, // Clock
   input wire wr_in, // Write pulse
   input wire [7:0] addr_in, // Address
   input wire [7:0] wdata_in, // Write data
   output wire [7:0] rdata_out // Read data
);
   reg [7:0] mem_reg [0:255];
   integer i;
   // Unwritten places read as the inverted address, never a plausible leftover
   initial for (i = 0; i < 256; i++) mem_reg[i] = ~i[7:0];
   assign rdata_out = mem_reg[addr_in];
   always @(posedge core_clk_in) begin
      if (wr_in) mem_reg[addr_in] <= wdata_in;
   end
endmodule // cmsd_periph_model

/* verification/cmsd_core_memory_bench.sv */
// Self-checking bench of the memory space decoder with a peripheral model.
// Assumes a 20 MHz clock and the one-request-per-cycle contract.
`timescale 1ns/1ns
module core_memory_space_decoder_bench;
   logic core_clk_in = 0, rst_in = 1, prog_rd_in = 0, xw = 0, acc_req_in = 0, acc_wr_in = 0, acc_bit_in = 0;
   logic push_in = 0, pop_in = 0;
   logic [15:0] prog_addr_in = 0;
   logic [7:0] prog_wdata_in = 0, acc_addr_in = 0, acc_wdata_in = 0, v [0:31], sd [0:2], u, w, mk;
   logic [1:0] acc_mode_in = 0;
   wire [7:0] prog_rdata_out, rdata_out, sfr_addr_out, sfr_wdata_out, sfr_rdata_in, sp, program_status_word, r0, r1;
   wire prog_valid_out, rdata_valid_out, sfr_wr_out;
   logic [7:0] dq [$], mq [$], pq [$];
   int failures = 0, n_compared = 0, i, bk;
   cmsd_core_memory u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .prog_addr_in(prog_addr_in),
      .prog_rd_in(prog_rd_in), .xdata_move_instr_wr_in(xw), .prog_wdata_in(prog_wdata_in),
      .prog_rdata_out(prog_rdata_out), .prog_valid_out(prog_valid_out), .prog_reserved_out(),
      .acc_req_in(acc_req_in), .acc_wr_in(acc_wr_in), .acc_mode_in(acc_mode_in), .acc_bit_in(acc_bit_in),
      .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .push_in(push_in), .pop_in(pop_in),
      .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .sfr_sel_out(), .sfr_wr_out(sfr_wr_out),
      .sfr_addr_out(sfr_addr_out), .sfr_wdata_out(sfr_wdata_out), .sfr_rdata_in(sfr_rdata_in),
      .stack_pointer_out(sp), .processor_status_word_out(program_status_word), .index_reg_zero_out(r0), .index_reg_one_out(r1));
   cmsd_periph_model u_per (.core_clk_in(core_clk_in), .wr_in(sfr_wr_out), .addr_in(sfr_addr_out),
      .wdata_in(sfr_wdata_out), .rdata_out(sfr_rdata_in));
   initial forever #25 core_clk_in = ~core_clk_in;
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic acc(input logic wr, input logic [1:0] m, input logic b, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      #1 acc_req_in = 1;
      {acc_wr_in, acc_mode_in, acc_bit_in, acc_addr_in, acc_wdata_in} = {wr, m, b, a, d};
      @(posedge core_clk_in);
      #1 acc_req_in = 0;
   endtask
   task automatic rd(input logic [1:0] m, input logic b, input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
      dq.push_back(e);
      mq.push_back(k);
      acc(0, m, b, a, 0);
   endtask
   task automatic prog(input logic wr, input logic [15:0] a, input logic [7:0] d);
      if (!wr) pq.push_back(d);
      @(posedge core_clk_in);
      #1 {xw, prog_rd_in, prog_addr_in, prog_wdata_in} = {wr, !wr, a, d};
      @(posedge core_clk_in);
      #1 {xw, prog_rd_in} = 2'b00;
   endtask
   task automatic stk(input logic ps);
      for (i = 0; i < 3; i++) begin
         @(posedge core_clk_in);
         #1 {push_in, pop_in, acc_wdata_in} = {ps, !ps, sd[i]};
         if (!ps) dq.push_back(sd[2-i]);
         if (!ps) mq.push_back(8'hff);
      end
      @(posedge core_clk_in);
      #1 {push_in, pop_in} = 2'b00;
   endtask
   always @(posedge core_clk_in) begin
      if (rdata_valid_out === 1'b1) begin
         mk = mq.pop_front();
         check(rdata_out & mk, dq.pop_front() & mk);
      end
      if (prog_valid_out === 1'b1) check(prog_rdata_out, pq.pop_front());
   end
   initial begin
      #(50 * 4000);
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(86764));
      repeat (10) @(posedge core_clk_in);
      #1 rst_in = 0;
      rd(0, 0, 8'h81, 8'h07, 8'hff);
      rd(0, 0, 8'hd0, 8'h00, 8'hff);
      for (bk = 0; bk < 4; bk++) begin
         acc(1, 0, 0, 8'hd0, 8'(bk << 3));
         check(program_status_word, 8'(bk << 3));
         for (i = 0; i < 8; i++) begin
            v[bk*8+i] = 8'($urandom);
            acc(1, 2, 0, 8'(i), v[bk*8+i]);
         end
         check(r0, v[bk*8]);
         check(r1, v[bk*8+1]);
      end
      for (i = 0; i < 32; i++) rd(0, 0, 8'(i), v[i], 8'hff);
      u = 8'($urandom);
      acc(1, 2, 0, 8'h00, 8'h90);
      acc(1, 1, 0, 8'h00, u);
      acc(1, 0, 0, 8'h90, ~u);
      // The address still stands from the write, as an outside read needs it a cycle early
      rd(0, 0, 8'h90, ~u, 8'hff);
      rd(1, 0, 8'h00, u, 8'hff);
      w = 8'($urandom);
      acc(1, 2, 0, 8'h01, 8'h35);
      acc(1, 0, 0, 8'h35, w);
      rd(1, 0, 8'h01, w, 8'hff);
      acc(1, 0, 0, 8'h22, u);
      rd(0, 1, 8'h13, {7'h00, u[3]}, 8'h01);
      acc(1, 0, 0, 8'h2f, 8'h00);
      acc(1, 0, 1, 8'h7f, 8'h01);
      rd(0, 0, 8'h2f, 8'h80, 8'hff);
      acc(1, 0, 1, 8'hd3, 8'h00);
      rd(0, 0, 8'hd0, 8'h10, 8'h18);
      acc(1, 0, 0, 8'h81, 8'h3f);
      for (i = 0; i < 3; i++) sd[i] = 8'($urandom);
      stk(1);
      check(sp, 8'h42);
      for (i = 0; i < 3; i++) rd(0, 0, 8'(8'h40 + i), sd[i], 8'hff);
      stk(0);
      check(sp, 8'h3f);
      acc(1, 0, 0, 8'h81, 8'hfe);
      stk(1);
      acc(1, 2, 0, 8'h00, 8'hff);
      rd(1, 0, 8'h00, sd[0], 8'hff);
      acc(1, 0, 0, 8'h8f, 8'h01);
      prog(1, 16'h1dff, u);
      prog(1, 16'h1e00, w);
      acc(1, 0, 0, 8'h8f, 8'h00);
      prog(1, 16'h1dff, ~u);
      prog(0, 16'h1dff, u);
      prog(0, 16'h1e00, 8'h00);
      prog(0, 16'hffff, 8'h00);
      repeat (3) @(posedge core_clk_in);
      // Mid-run reset must restore the pointer and the status word
      #1 rst_in = 1;
      repeat (2) @(posedge core_clk_in);
      #1 rst_in = 0;
      check(sp, 8'h07);
      check(program_status_word, 8'h00);
      rd(0, 0, 8'h81, 8'h07, 8'hff);
      repeat (3) @(posedge core_clk_in);
      check(8'(dq.size() + pq.size()), 8'h00);
      complete_run();
   end
endmodule // core_memory_space_decoder_bench
